// >>> bench/aau_address_units_sva.sv
`timescale 1ns/1ps
`include "aau_consts.vh"
module aau_address_units_sva (
    // clock and reset
    input wire mclk,
    input wire rst,
    // bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // decoder side
    input wire [2:0] pcOp,
    input wire tableAccess,
    input wire tableModSel,
    input wire ramAccess,
    input wire [1:0] ramPtrSel,
    input wire [2:0] ramModSel,
    // addresses and side effects
    input wire [15:0] romAddr,
    input wire [15:0] tableAddr,
    input wire [15:0] ramAddr,
    input wire prngReset
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // call immediately followed by a return
    sequence callThenRet;
        (pcOp == `AAU_PC_CALL) ##1 (pcOp == `AAU_PC_RET);
    endsequence
    // two table accesses in a row, the first stepping by one
    sequence tableIncPair;
        (tableAccess && tableModSel == `AAU_PT_INC) ##1 tableAccess;
    endsequence
    // decrement followed by another access of the same pointer
    sequence ramDecPair;
        (ramAccess && ramModSel == `AAU_RM_DEC) ##1 (ramAccess && ramPtrSel == $past(ramPtrSel));
    endsequence

    pc_step_a: assert property (pcOp == `AAU_PC_STEP |=> romAddr == $past(romAddr) + 16'h1)
        else $error("counter step wrong");
    call_return_a: assert property (callThenRet |=> romAddr == $past(romAddr, 2) + 16'h1)
        else $error("return address wrong");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    table_inc_a: assert property (tableIncPair |=> tableAddr[15:12] == $past(tableAddr[15:12])
        && tableAddr[11:0] == $past(tableAddr[11:0]) + 12'h1) else $error("table step wrong");
    ram_dec_a: assert property (ramDecPair |=> ramAddr == $past(ramAddr) - 16'h1)
        else $error("pointer decrement wrong");
    prng_pulse_a: assert property (prngReset |=> !prngReset)
        else $error("generator reset not a pulse");
endmodule // aau_address_units_sva

bind aau_address_units aau_address_units_sva aau_address_units_sva_i (
    .mclk(mclk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pcOp(pcOp),
    .tableAccess(tableAccess), .tableModSel(tableModSel), .ramAccess(ramAccess),
    .ramPtrSel(ramPtrSel), .ramModSel(ramModSel), .romAddr(romAddr), .tableAddr(tableAddr),
    .ramAddr(ramAddr), .prngReset(prngReset)
);

// >>> bench/test_aau_address_units.sv
`timescale 1ns/1ps
`include "aau_consts.vh"
module test_aau_address_units;
    // stimulus and observed signals
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [2:0] pcOp = 3'h0, ramModSel = 3'h0;
    logic [15:0] pcTarget = 16'h0;
    logic inIsr = 1'b0, tableAccess = 1'b0, tableModSel = 1'b0, ramAccess = 1'b0;
    logic [1:0] ramPtrSel = 2'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, prngReset;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] romAddr, tableAddr, ramAddr;
    int mismatches = 0, totalChecks = 0, cycles = 0, prngCount = 0;
    logic [15:0] dlt [8] = '{16'h0, 16'h1, 16'hffff, 16'h2, 16'hfffd, 16'h5, 16'h0, 16'h0};

    aau_address_units aau_address_units_i (
        .mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pcOp(pcOp), .pcTarget(pcTarget), .inIsr(inIsr),
        .tableAccess(tableAccess), .tableModSel(tableModSel), .ramAccess(ramAccess),
        .ramPtrSel(ramPtrSel), .ramModSel(ramModSel), .romAddr(romAddr),
        .tableAddr(tableAddr), .ramAddr(ramAddr), .prngReset(prngReset)
    );

    always #5 mclk = ~mclk;

    // cycle watchdog and generator reset pulse count
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (prngReset === 1'b1) prngCount <= prngCount + 1;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic c16(input string nm, input logic [15:0] e, input logic [15:0] g);
        chk(nm, {16'h0, e}, {16'h0, g});
    endtask

    // bus write: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa;
        logic pw;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        do begin
            @(posedge mclk);
            if (pa && s_axi_awready === 1'b1) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (pw && s_axi_wready === 1'b1) begin
                pw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    // bus read with expected data and response
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic pa;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        pa = 1'b1;
        do begin
            @(posedge mclk);
            if (pa && s_axi_arready === 1'b1) begin
                pa = 1'b0;
                s_axi_arvalid <= 1'b0;
            end else if (!pa && s_axi_rready !== 1'b1) begin
                s_axi_rready <= 1'b1; // late ready: answer must stand one cycle
            end
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // one decoder cycle; outputs of the previous edge are settled on return
    task automatic dec(input logic [2:0] op, input logic [15:0] t, input logic ta, input logic ts,
        input logic ra, input logic [1:0] rp, input logic [2:0] rs);
        @(posedge mclk);
        pcOp <= op;
        pcTarget <= t;
        tableAccess <= ta;
        tableModSel <= ts;
        ramAccess <= ra;
        ramPtrSel <= rp;
        ramModSel <= rs;
        #1;
    endtask

    task automatic idle();
        dec(`AAU_PC_HOLD, 16'h0, 1'b0, 1'b0, 1'b0, 2'h0, 3'h0);
    endtask

    task automatic pc(input logic [2:0] op, input logic [15:0] t);
        dec(op, t, 1'b0, 1'b0, 1'b0, 2'h0, 3'h0);
    endtask

    // four back-to-back pointer accesses against a ring model
    task automatic ring(input logic [1:0] p, input logic [15:0] st, input logic [15:0] rb,
        input logic [15:0] re, input logic [2:0] ms, input logic [15:0] step);
        logic [15:0] e;
        axw(`AAU_OFF_RB, {16'h0, rb}, `AAU_RESP_OKAY);
        axw(`AAU_OFF_RE, {16'h0, re}, `AAU_RESP_OKAY);
        axw(`AAU_OFF_R0 + {4'h0, p, 2'h0}, {16'h0, st}, `AAU_RESP_OKAY);
        e = st;
        for (int i = 0; i < 4; i++) begin
            dec(`AAU_PC_HOLD, 16'h0, 1'b0, 1'b0, 1'b1, p, ms);
            if (i > 0) begin
                c16("ramAddr", e, ramAddr);
                e = (re != 16'h0 && e == re && ms == `AAU_RM_INC) ? rb : e + step;
            end
        end
        idle();
        c16("ramAddr", e, ramAddr);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        int p0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 13; i++) rdc(8'(i * 4), 32'h0, `AAU_RESP_OKAY);
        rdc(8'h38, 32'h0, `AAU_RESP_SLVERR);
        axw(`AAU_OFF_PC, 32'h5, `AAU_RESP_SLVERR);
        axw(`AAU_OFF_OFS, 32'h800, `AAU_RESP_OKAY);
        rdc(`AAU_OFF_OFS, 32'hf800, `AAU_RESP_OKAY);
        axw(`AAU_OFF_OFS, 32'h7ff, `AAU_RESP_OKAY);
        rdc(`AAU_OFF_OFS, 32'h7ff, `AAU_RESP_OKAY);
        axw(`AAU_OFF_OFS, 32'hffe, `AAU_RESP_OKAY);
        // jump, call and return back to back
        pc(`AAU_PC_STEP, 16'h0);
        pc(`AAU_PC_JUMP, 16'h1234);
        c16("romAddr", 16'h1, romAddr);
        pc(`AAU_PC_CALL, 16'h4000);
        c16("romAddr", 16'h1234, romAddr);
        pc(`AAU_PC_RET, 16'h0);
        c16("romAddr", 16'h4000, romAddr);
        idle();
        c16("romAddr", 16'h1235, romAddr);
        rdc(`AAU_OFF_PR, 32'h1235, `AAU_RESP_OKAY);
        rdc(`AAU_OFF_PI, 32'h1235, `AAU_RESP_OKAY);
        // interrupt service freezes the shadow
        @(posedge mclk);
        inIsr <= 1'b1;
        pc(`AAU_PC_JUMP, 16'h5000);
        idle();
        rdc(`AAU_OFF_PI, 32'h1235, `AAU_RESP_OKAY);
        axw(`AAU_OFF_PI, 32'h777, `AAU_RESP_OKAY);
        rdc(`AAU_OFF_PI, 32'h777, `AAU_RESP_OKAY);
        pc(`AAU_PC_IRET, 16'h0);
        idle();
        c16("romAddr", 16'h777, romAddr);
        @(posedge mclk);
        inIsr <= 1'b0;
        p0 = prngCount;
        axw(`AAU_OFF_PI, 32'habc, `AAU_RESP_OKAY);
        idle();
        idle();
        c16("prngCount", 16'(p0 + 1), 16'(prngCount));
        rdc(`AAU_OFF_PI, 32'h777, `AAU_RESP_OKAY);
        pc(`AAU_PC_STEP, 16'h0);
        idle();
        rdc(`AAU_OFF_PI, 32'h778, `AAU_RESP_OKAY);
        // table pointer wraps within its page
        axw(`AAU_OFF_PT, 32'h3ffe, `AAU_RESP_OKAY);
        dec(`AAU_PC_HOLD, 16'h0, 1'b1, `AAU_PT_INC, 1'b0, 2'h0, 3'h0);
        dec(`AAU_PC_HOLD, 16'h0, 1'b1, `AAU_PT_INC, 1'b0, 2'h0, 3'h0);
        c16("tableAddr", 16'h3ffe, tableAddr);
        dec(`AAU_PC_HOLD, 16'h0, 1'b1, `AAU_PT_OFS, 1'b0, 2'h0, 3'h0);
        c16("tableAddr", 16'h3fff, tableAddr);
        idle();
        c16("tableAddr", 16'h3000, tableAddr);
        rdc(`AAU_OFF_PT, 32'h3ffe, `AAU_RESP_OKAY);
        pc(`AAU_PC_GOTO_PT, 16'h0);
        idle();
        c16("romAddr", 16'h3ffe, romAddr);
        axw(`AAU_OFF_PT, 32'hffff, `AAU_RESP_OKAY);
        rdc(`AAU_OFF_PT, 32'hffff, `AAU_RESP_OKAY);
        pc(`AAU_PC_CALL_PT, 16'h0);
        idle();
        c16("romAddr", 16'hffff, romAddr);
        rdc(`AAU_OFF_PR, 32'h3fff, `AAU_RESP_OKAY);
        // ram pointer steps and ring buffers
        axw(`AAU_OFF_J, 32'hfffd, `AAU_RESP_OKAY);
        axw(`AAU_OFF_K, 32'h5, `AAU_RESP_OKAY);
        rdc(`AAU_OFF_J, 32'hfffd, `AAU_RESP_OKAY);
        for (int m = 0; m < 8; m++) ring(2'h1, 16'h100, 16'h0, 16'h0, 3'(m), dlt[m]);
        ring(2'h2, 16'h21, 16'h20, 16'h22, `AAU_RM_INC, 16'h1);
        ring(2'h2, 16'h22, 16'h20, 16'h22, `AAU_RM_INC2, 16'h2);
        ring(2'h0, 16'h7fe, 16'h0, 16'h7ff, `AAU_RM_INC, 16'h1);
        ring(2'h3, 16'h0, 16'h10, 16'h0, `AAU_RM_INC, 16'h1);
        summarize();
    end
endmodule // test_aau_address_units

// >>> hw/aau_address_units.v
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "aau_consts.vh"

// How it works
// [RQ1] program unit: 12-bit adder, 12-bit offset, four 16-bit pointers
// [RQ2] call saves return in return register; returns reload counter from it or shadow
// [RQ3] program counter can be loaded from the table pointer
// [RQ4] table pointer post-modified by one or by the signed offset
// [RQ5] offset is 12-bit signed, sign-extended to 16 bits when read out
// [RQ6] post-modify touches only low 12 bits; page bits change by load only
// [RQ7] table pointer is a full 16-bit loadable register
// [RQ8] outside interrupt service every new counter value is copied to the shadow
// [RQ9] return from interrupt is a jump to the shadow value
// [RQ10] shadow writes work only in service; outside they reset the random generator
// [RQ11] data unit has eight loadable registers and an adder, 16 bits wide
// [RQ12] ram pointers step by 0, +1, -1, +2, or either step register
// [RQ13] step registers hold signed 16-bit values
// [RQ14] pointer equal to ring end with +1 step reloads from ring base
// [RQ15] ring buffers up to 2048 words are supported
// [RQ16] ring disabled while end is zero; reset clears the end register
// [RQ17] modifications follow the access; comparison uses the unmodified value
// [RQ18] table pointer adder carry or borrow is dropped, wrapping in its page
module aau_address_units (
    // clock and reset
    input wire mclk,
    input wire rst,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // program sequencing from the decoder
    input wire [2:0] pcOp,
    input wire [15:0] pcTarget,
    input wire inIsr,
    // table access from the decoder
    input wire tableAccess,
    input wire tableModSel,
    // ram access from the decoder
    input wire ramAccess,
    input wire [1:0] ramPtrSel,
    input wire [2:0] ramModSel,
    // addresses and side effects
    output reg [15:0] romAddr,
    output reg [15:0] tableAddr,
    output reg [15:0] ramAddr,
    output reg prngReset
);

    // program unit registers
    reg [15:0] programCounter;
    reg [15:0] subroutineReturnAddr;
    reg [15:0] interruptReturnShadow;
    reg [15:0] tablePointer;
    reg [11:0] offsetReg;
    // data unit registers besides the pointers
    reg [15:0] stepJ;
    reg [15:0] stepK;
    reg [15:0] ringBaseAddr;
    reg [15:0] ringEndAddr;

    // axi write holding
    reg awHeld;
    reg [7:0] awAddrQ;
    reg wHeld;
    reg [31:0] wDataQ;
    reg [3:0] wStrbQ;

    wire doWrite;
    wire [5:0] wrIdx;
    wire [5:0] rdIdx;
    wire wrPc, wrPr, wrPi, wrPt, wrOfs, wrJ, wrK, wrRb, wrRe;
    wire [3:0] wrPtr;
    wire wrMapped;
    wire rdMapped;
    wire [63:0] ptrFlat;
    wire [15:0] nextPtrFlat;
    wire [15:0] ofsExt;
    wire [11:0] ptStep;
    reg [15:0] next_pc;
    reg pcChange;
    reg [15:0] rdWord;

    // merge byte lanes 0 and 1 into a 16-bit register
    function [15:0] laneMerge;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            laneMerge[7:0] = strb[0] ? data[7:0] : old[7:0];
            laneMerge[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    // channel readiness: one held address and one held datum at most
    assign s_axi_awready = ~awHeld;
    assign s_axi_wready = ~wHeld;
    assign s_axi_arready = ~s_axi_rvalid;
    assign doWrite = awHeld & wHeld & ~s_axi_bvalid;

    // write address decode
    assign wrIdx = awAddrQ[7:2];
    assign wrPc = doWrite && (wrIdx == `AAU_OFF_PC >> 2);
    assign wrPr = doWrite && (wrIdx == `AAU_OFF_PR >> 2);
    assign wrPi = doWrite && (wrIdx == `AAU_OFF_PI >> 2);
    assign wrPt = doWrite && (wrIdx == `AAU_OFF_PT >> 2);
    assign wrOfs = doWrite && (wrIdx == `AAU_OFF_OFS >> 2);
    assign wrJ = doWrite && (wrIdx == `AAU_OFF_J >> 2);
    assign wrK = doWrite && (wrIdx == `AAU_OFF_K >> 2);
    assign wrRb = doWrite && (wrIdx == `AAU_OFF_RB >> 2);
    assign wrRe = doWrite && (wrIdx == `AAU_OFF_RE >> 2);
    assign wrMapped = wrPr | wrPi | wrPt | wrOfs | wrJ | wrK | wrRb | wrRe | (|wrPtr);
    assign rdIdx = s_axi_araddr[7:2];
    assign rdMapped = (rdIdx <= (`AAU_OFF_STAT >> 2));

    // write address and data channels, taken in either order
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            awHeld <= 1'b0;
            awAddrQ <= 8'h00;
            wHeld <= 1'b0;
            wDataQ <= 32'h00000000;
            wStrbQ <= 4'h0;
        end else begin
            if (s_axi_awvalid && !awHeld) begin
                awHeld <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && !wHeld) begin
                wHeld <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    // write response: slverr for the read-only or unmapped words
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AAU_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? `AAU_RESP_OKAY : `AAU_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // offset sign-extended whenever it leaves the unit
    assign ofsExt = {{4{offsetReg[11]}}, offsetReg}; // RQ5

    // read mux, upper half reads zero
    always @* begin
        case (rdIdx)
            `AAU_OFF_PC >> 2: rdWord = programCounter;
            `AAU_OFF_PR >> 2: rdWord = subroutineReturnAddr;
            `AAU_OFF_PI >> 2: rdWord = interruptReturnShadow;
            `AAU_OFF_PT >> 2: rdWord = tablePointer;
            `AAU_OFF_OFS >> 2: rdWord = ofsExt; // RQ5
            `AAU_OFF_R0 >> 2: rdWord = ptrFlat[15:0];
            `AAU_OFF_R1 >> 2: rdWord = ptrFlat[31:16];
            `AAU_OFF_R2 >> 2: rdWord = ptrFlat[47:32];
            `AAU_OFF_R3 >> 2: rdWord = ptrFlat[63:48];
            `AAU_OFF_J >> 2: rdWord = stepJ;
            `AAU_OFF_K >> 2: rdWord = stepK;
            `AAU_OFF_RB >> 2: rdWord = ringBaseAddr;
            `AAU_OFF_RE >> 2: rdWord = ringEndAddr;
            `AAU_OFF_STAT >> 2: rdWord = {15'h0, inIsr};
            default: rdWord = 16'h0000;
        endcase
    end

    // read channel: answer one cycle after the address is taken
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AAU_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rdWord};
            s_axi_rresp <= rdMapped ? `AAU_RESP_OKAY : `AAU_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // next program counter from the decoder operation
    always @* begin
        next_pc = programCounter;
        pcChange = 1'b1;
        case (pcOp)
            `AAU_PC_STEP: next_pc = programCounter + 16'h0001;
            `AAU_PC_JUMP: next_pc = pcTarget;
            `AAU_PC_CALL: next_pc = pcTarget;
            `AAU_PC_RET: next_pc = subroutineReturnAddr; // RQ2
            `AAU_PC_IRET: next_pc = interruptReturnShadow; // RQ2 RQ9
            `AAU_PC_GOTO_PT: next_pc = tablePointer; // RQ3 RQ6
            `AAU_PC_CALL_PT: next_pc = tablePointer; // RQ3 RQ6
            default: pcChange = 1'b0;
        endcase
    end

    // program counter and subroutine return register
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            programCounter <= `AAU_RST_WORD;
            subroutineReturnAddr <= `AAU_RST_WORD;
        end else begin
            programCounter <= next_pc; // RQ1
            if (wrPr) begin
                subroutineReturnAddr <= laneMerge(subroutineReturnAddr, wDataQ, wStrbQ);
            end else if (pcOp == `AAU_PC_CALL || pcOp == `AAU_PC_CALL_PT) begin
                subroutineReturnAddr <= programCounter + 16'h0001; // RQ2
            end
        end
    end

    // interrupt return shadow and generator reset pulse
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            interruptReturnShadow <= `AAU_RST_WORD;
            prngReset <= 1'b0;
        end else begin
            prngReset <= wrPi & ~inIsr; // RQ10
            if (wrPi && inIsr) begin
                interruptReturnShadow <= laneMerge(interruptReturnShadow, wDataQ, wStrbQ); // RQ10
            end else if (pcChange && !inIsr) begin
                interruptReturnShadow <= next_pc; // RQ8
            end
        end
    end

    // table pointer: 12-bit post-modify inside the current page
    assign ptStep = (tableModSel == `AAU_PT_OFS) ? offsetReg : 12'h001; // RQ4
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tablePointer <= `AAU_RST_WORD;
            offsetReg <= `AAU_RST_OFS;
        end else begin
            if (wrPt) begin
                tablePointer <= laneMerge(tablePointer, wDataQ, wStrbQ); // RQ7
            end else if (tableAccess) begin
                tablePointer <= {tablePointer[15:12], tablePointer[11:0] + ptStep}; // RQ6 RQ18
            end
            if (wrOfs) begin
                offsetReg[7:0] <= wStrbQ[0] ? wDataQ[7:0] : offsetReg[7:0]; // RQ5
                offsetReg[11:8] <= wStrbQ[1] ? wDataQ[11:8] : offsetReg[11:8];
            end
        end
    end

    // step and ring registers; end clears at reset
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            stepJ <= `AAU_RST_WORD;
            stepK <= `AAU_RST_WORD;
            ringBaseAddr <= `AAU_RST_WORD;
            ringEndAddr <= `AAU_RST_WORD; // RQ16
        end else begin
            if (wrJ) begin
                stepJ <= laneMerge(stepJ, wDataQ, wStrbQ); // RQ13
            end
            if (wrK) begin
                stepK <= laneMerge(stepK, wDataQ, wStrbQ); // RQ13
            end
            if (wrRb) begin
                ringBaseAddr <= laneMerge(ringBaseAddr, wDataQ, wStrbQ);
            end
            if (wrRe) begin
                ringEndAddr <= laneMerge(ringEndAddr, wDataQ, wStrbQ);
            end
        end
    end

    // shared data-unit adder on the selected pointer
    aau_ptr_modify u_modify (
        .ptr(ptrFlat[ramPtrSel*16 +: 16]),
        .modSel(ramModSel),
        .stepJ(stepJ),
        .stepK(stepK),
        .ringBase(ringBaseAddr),
        .ringEnd(ringEndAddr),
        .nextPtr(nextPtrFlat[15:0])
    ); // RQ11 RQ12 RQ14

    // four ram pointers, each loadable and post-modified after its access
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_ptr
            reg [15:0] ramPointer;
            assign wrPtr[g] = doWrite && (wrIdx == ((`AAU_OFF_R0 >> 2) + g));
            assign ptrFlat[g*16 +: 16] = ramPointer;
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    ramPointer <= `AAU_RST_WORD;
                end else if (wrPtr[g]) begin
                    ramPointer <= laneMerge(ramPointer, wDataQ, wStrbQ); // RQ11
                end else if (ramAccess && (ramPtrSel == g)) begin
                    ramPointer <= nextPtrFlat[15:0]; // RQ15 RQ17
                end
            end
        end
    endgenerate

    // address outputs: table and ram accesses use the pointer before its update; romAddr takes the new counter value
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            romAddr <= `AAU_RST_WORD;
            tableAddr <= `AAU_RST_WORD;
            ramAddr <= `AAU_RST_WORD;
        end else begin
            romAddr <= next_pc;
            if (tableAccess) begin
                tableAddr <= tablePointer; // RQ17
            end
            if (ramAccess) begin
                ramAddr <= ptrFlat[ramPtrSel*16 +: 16]; // RQ17
            end
        end
    end

endmodule // aau_address_units

// >>> hw/aau_consts.vh
`ifndef AAU_CONSTS_VH
`define AAU_CONSTS_VH

// word widths
`define AAU_PC_W 16
`define AAU_OFS_W 12
`define AAU_RAM_W 16

// register byte offsets on the axi4-lite slave
`define AAU_OFF_PC 8'h00
`define AAU_OFF_PR 8'h04
`define AAU_OFF_PI 8'h08
`define AAU_OFF_PT 8'h0c
`define AAU_OFF_OFS 8'h10
`define AAU_OFF_R0 8'h14
`define AAU_OFF_R1 8'h18
`define AAU_OFF_R2 8'h1c
`define AAU_OFF_R3 8'h20
`define AAU_OFF_J 8'h24
`define AAU_OFF_K 8'h28
`define AAU_OFF_RB 8'h2c
`define AAU_OFF_RE 8'h30
`define AAU_OFF_STAT 8'h34

// status register field
`define AAU_STAT_ISR_BIT 0

// program counter operations from the decoder
`define AAU_PC_HOLD 3'h0
`define AAU_PC_STEP 3'h1
`define AAU_PC_JUMP 3'h2
`define AAU_PC_CALL 3'h3
`define AAU_PC_RET 3'h4
`define AAU_PC_IRET 3'h5
`define AAU_PC_GOTO_PT 3'h6
`define AAU_PC_CALL_PT 3'h7

// table pointer modifier select
`define AAU_PT_INC 1'b0
`define AAU_PT_OFS 1'b1

// ram pointer modifier select
`define AAU_RM_ZERO 3'h0
`define AAU_RM_INC 3'h1
`define AAU_RM_DEC 3'h2
`define AAU_RM_INC2 3'h3
`define AAU_RM_J 3'h4
`define AAU_RM_K 3'h5

// reset values
`define AAU_RST_WORD 16'h0000
`define AAU_RST_OFS 12'h000

// axi responses
`define AAU_RESP_OKAY 2'b00
`define AAU_RESP_SLVERR 2'b10

`endif

// >>> hw/aau_ptr_modify.v
`timescale 1ns/1ps
`include "aau_consts.vh"

module aau_ptr_modify (
    // pointer before the access
    input wire [`AAU_RAM_W-1:0] ptr,
    input wire [2:0] modSel,
    // step and ring registers
    input wire [`AAU_RAM_W-1:0] stepJ,
    input wire [`AAU_RAM_W-1:0] stepK,
    input wire [`AAU_RAM_W-1:0] ringBase,
    input wire [`AAU_RAM_W-1:0] ringEnd,
    // pointer after the access
    output reg [`AAU_RAM_W-1:0] nextPtr
);

    reg [`AAU_RAM_W-1:0] step;

    // select the step, then wrap at the ring end on a +1 step
    always @* begin
        case (modSel)
            `AAU_RM_ZERO: step = 16'h0000;
            `AAU_RM_INC: step = 16'h0001;
            `AAU_RM_DEC: step = 16'hffff;
            `AAU_RM_INC2: step = 16'h0002;
            `AAU_RM_J: step = stepJ; // RQ13
            `AAU_RM_K: step = stepK; // RQ13
            default: step = 16'h0000;
        endcase
        nextPtr = ptr + step; // RQ12
        // compare uses the pre-access value; zero end disables the ring
        if ((ringEnd != 16'h0000) && (ptr == ringEnd) && (modSel == `AAU_RM_INC)) begin
            nextPtr = ringBase; // RQ14 RQ16 RQ17
        end
    end

endmodule // aau_ptr_modify
